// ===== ioc_pkg.sv
// Function
// R1: enable 00 off, 11 run, suspend stops it
// R2: writing suspend bit halts oscillator until wake
// R3: port match or comparator low ends suspend
// R4: software sets zero-tc bias before suspend
// R5: bit 4 reads frequency-ready, read only
// R6: control bit 3 reads zero, write zero
// R7: select 000 divides 128 down to 111 divides 1
// R8: reset returns divider select to 128
// R9: divided clock used when source select 00
// R10: seven-bit coarse trim, 0 slowest, readable writable
// R11: six-bit fine trim bits 5:0 readable writable
// R12: trims load factory calibration values on reset
// R13: unused trim bits read zero, ignore writes
// R14: divider change applies at divided-clock boundary
package ioc_pkg;
	localparam logic [7:0] IOC_FINE_ADDR = 8'h9e;
	localparam logic [7:0] IOC_CTRL_ADDR = 8'ha1;
	localparam logic [7:0] IOC_COARSE_ADDR = 8'ha2;
	localparam int IOC_EN_MSB = 7;
	localparam int IOC_EN_LSB = 6;
	localparam int IOC_SUSP_BIT = 5;
	localparam int IOC_RDY_BIT = 4;
	localparam int IOC_RSVD_BIT = 3;
	localparam logic [1:0] IOC_EN_OFF = 2'h0;
	localparam logic [1:0] IOC_EN_RUN = 2'h3;
	localparam logic [1:0] IOC_EN_RST = 2'h3;
	localparam logic [2:0] IOC_SEL_RST = 3'h0;
	localparam logic [2:0] IOC_SEL_DIV1 = 3'h7;
	localparam logic [1:0] IOC_SRC_INTOSC = 2'h0;
	localparam int IOC_DIV_W = 7;
	localparam int IOC_COARSE_W = 7;
	localparam int IOC_FINE_W = 6;
	localparam logic [6:0] IOC_DIV_MASK = 7'h7f;
	localparam int IOC_OSC_MHZ = 24;
	typedef struct packed {
		logic [3:0] port_match;
		logic cmp0_en;
		logic cmp0_out;
	} ioc_wake_t;
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} ioc_sfr_t;
endpackage

// ===== ioc_ctrl.sv
`timescale 1ns/10ps
module ioc_ctrl #(
	parameter int DIV_W = 7,
	parameter int COARSE_W = 7,
	parameter int FINE_W = 6
) (
	input wire logic clock,
	input wire logic srst,
	input wire ioc_pkg::ioc_sfr_t sfr,
	output logic [7:0] sfr_rdata,
	input wire ioc_pkg::ioc_wake_t wake,
	input wire logic [6:0] cal_coarse,
	input wire logic [5:0] cal_fine,
	input wire logic osc_tick,
	input wire logic osc_at_freq,
	input wire logic [1:0] clock_source_select,
	output logic osc_run,
	output logic [6:0] coarse_trim,
	output logic [5:0] fine_trim,
	output logic int_osc_div_tick,
	output logic system_clock_tick
);
	import ioc_pkg::*;

	// widths are tied to the register layout; other values cannot be served
	if (DIV_W != IOC_DIV_W || COARSE_W != IOC_COARSE_W || FINE_W != IOC_FINE_W) begin
		$error("ioc_ctrl: field widths are fixed by the register layout");
	end

	logic [1:0] osc_enable_field_r;
	logic susp_r;
	logic [2:0] system_clock_divide_select_r;
	logic [2:0] act_sel_r;
	logic [6:0] coarse_r;
	logic [5:0] fine_r;
	logic [6:0] div_cnt_r;
	logic [6:0] div_cnt_nxt;
	logic [7:0] rdata_r;
	logic div_tick_r;
	logic sys_tick_r;

	// decode
	wire wr_ctrl = sfr.wr && (sfr.addr == IOC_CTRL_ADDR);
	wire wr_coarse = sfr.wr && (sfr.addr == IOC_COARSE_ADDR);
	wire wr_fine = sfr.wr && (sfr.addr == IOC_FINE_ADDR);
	wire rd_ctrl = sfr.addr == IOC_CTRL_ADDR;
	wire rd_coarse = sfr.addr == IOC_COARSE_ADDR;
	wire rd_fine = sfr.addr == IOC_FINE_ADDR;
	wire [1:0] wr_en_field = sfr.wdata[IOC_EN_MSB:IOC_EN_LSB];
	wire wr_susp = sfr.wdata[IOC_SUSP_BIT];

	// wake sources
	wire wake_any = (|wake.port_match) || (wake.cmp0_en && !wake.cmp0_out); // [R3]

	// oscillator runs only in run mode and outside suspend
	wire run_now = (osc_enable_field_r == IOC_EN_RUN) && !susp_r; // [R1]
	assign osc_run = run_now;

	// the ready flag is a hint only; it follows the analog ready while running
	wire freq_ready_flag = run_now && osc_at_freq; // [R5]

	// suspend: software write sets, wake clears; a write in the wake cycle
	// wins so the request is not lost, and a still-active wake ends it next cycle
	wire susp_nxt = (wr_ctrl && wr_susp) ? 1'b1 : (wake_any ? 1'b0 : susp_r); // [R2]

	// divider: divisor minus one is the mask shifted by the active select
	wire [6:0] div_top = IOC_DIV_MASK >> act_sel_r; // [R7]
	wire osc_edge = osc_tick && run_now; // [R3]
	wire div_last = osc_edge && (div_cnt_r == div_top);
	assign div_cnt_nxt = div_last ? 7'h00 : (osc_edge ? div_cnt_r + 7'h01 : div_cnt_r);

	// reads
	wire [7:0] ctrl_rd_val = {osc_enable_field_r, susp_r, freq_ready_flag, 1'b0,
		system_clock_divide_select_r}; // [R5] [R6]
	wire [7:0] coarse_rd_val = {1'b0, coarse_r}; // [R10] [R13]
	wire [7:0] fine_rd_val = {2'h0, fine_r}; // [R11] [R13]
	wire [7:0] rd_mux = rd_ctrl ? ctrl_rd_val : (rd_coarse ? coarse_rd_val :
		(rd_fine ? fine_rd_val : 8'h00));

	always_ff @(posedge clock) begin
		if (srst) begin
			osc_enable_field_r <= IOC_EN_RST;
			susp_r <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				osc_enable_field_r <= wr_en_field; // [R1]
			end
			susp_r <= susp_nxt; // [R2] [R3]
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			system_clock_divide_select_r <= IOC_SEL_RST; // [R8]
			act_sel_r <= IOC_SEL_RST; // [R8]
			div_cnt_r <= 7'h00;
		end else begin
			if (wr_ctrl) begin
				system_clock_divide_select_r <= sfr.wdata[2:0]; // [R7]
			end
			// new select only at a boundary, so no phase is cut short
			if (div_last) begin
				act_sel_r <= system_clock_divide_select_r; // [R14]
			end
			div_cnt_r <= div_cnt_nxt;
		end
	end

	// factory trims are taken at reset, after that software owns them
	always_ff @(posedge clock) begin
		if (srst) begin
			coarse_r <= cal_coarse; // [R12]
			fine_r <= cal_fine; // [R12]
		end else begin
			if (wr_coarse) begin
				coarse_r <= sfr.wdata[6:0]; // [R10] [R13]
			end
			if (wr_fine) begin
				fine_r <= sfr.wdata[5:0]; // [R11] [R13]
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			rdata_r <= 8'h00;
			div_tick_r <= 1'b0;
			sys_tick_r <= 1'b0;
		end else begin
			if (sfr.rd) begin
				rdata_r <= rd_mux;
			end
			div_tick_r <= div_last;
			sys_tick_r <= div_last && (clock_source_select == IOC_SRC_INTOSC); // [R9]
		end
	end

	assign sfr_rdata = rdata_r;
	assign coarse_trim = coarse_r;
	assign fine_trim = fine_r;
	assign int_osc_div_tick = div_tick_r;
	assign system_clock_tick = sys_tick_r;

	// helper for the period check: oscillator edges since the last boundary
	logic [7:0] per_cnt_r;

	always_ff @(posedge clock) begin
		if (srst) begin
			per_cnt_r <= 8'h00;
		end else if (div_last) begin
			per_cnt_r <= 8'h00;
		end else if (osc_edge) begin
			per_cnt_r <= per_cnt_r + 8'h01;
		end
	end

	// checks
	sequence ctrl_write_off_s;
		wr_ctrl && (wr_en_field == IOC_EN_OFF);
	endsequence

	sequence ctrl_write_susp_s;
		wr_ctrl && wr_susp && (wr_en_field == IOC_EN_RUN);
	endsequence

	sequence quiet_s;
		!osc_run ##1 !system_clock_tick;
	endsequence

	osc_off_a: assert property (@(posedge clock) disable iff (srst) // [R1]
		ctrl_write_off_s |-> ##1 quiet_s ##1 !system_clock_tick)
		else $error("oscillator still active after enable cleared");

	suspend_halt_a: assert property (@(posedge clock) disable iff (srst) // [R2]
		ctrl_write_susp_s |-> ##1 (susp_r and quiet_s))
		else $error("suspend write did not halt oscillator");

	wake_end_a: assert property (@(posedge clock) disable iff (srst) // [R3]
		(susp_r && wake_any && !wr_ctrl && osc_enable_field_r == IOC_EN_RUN)
		|-> ##1 (!susp_r && osc_run))
		else $error("wake event did not end suspend");

	susp_hold_a: assert property (@(posedge clock) disable iff (srst) // [R3]
		(susp_r && !wake_any) |-> ##1 susp_r)
		else $error("suspend ended without wake");

	ready_read_a: assert property (@(posedge clock) disable iff (srst) // [R5]
		(sfr.rd && rd_ctrl) |-> ##1 (sfr_rdata[IOC_RDY_BIT] ==
		($past(osc_at_freq) && $past(osc_run))))
		else $error("ready flag read wrong");

	rsvd_zero_a: assert property (@(posedge clock) disable iff (srst) // [R6]
		$past(sfr.rd && rd_ctrl) |-> !sfr_rdata[IOC_RSVD_BIT])
		else $error("reserved control bit read one");

	div1_rate_a: assert property (@(posedge clock) disable iff (srst) // [R7]
		(act_sel_r == IOC_SEL_DIV1 && osc_edge) |-> ##1 int_osc_div_tick)
		else $error("divide by one missed a tick");

	div128_gap_a: assert property (@(posedge clock) disable iff (srst) // [R7]
		(int_osc_div_tick && act_sel_r == IOC_SEL_RST) |-> ##1 !int_osc_div_tick[*8])
		else $error("divide by 128 ticked too soon");

	sel_reset_a: assert property (@(posedge clock) // [R8]
		$past(srst) |-> (system_clock_divide_select_r == IOC_SEL_RST && act_sel_r == IOC_SEL_RST))
		else $error("divider not at 128 after reset");

	src_gate_a: assert property (@(posedge clock) disable iff (srst) // [R9]
		(clock_source_select != IOC_SRC_INTOSC) |-> ##1 !system_clock_tick)
		else $error("system clock tick with other source");

	trim_reset_a: assert property (@(posedge clock) // [R12]
		$past(srst) |-> (coarse_trim == $past(cal_coarse) && fine_trim == $past(cal_fine)))
		else $error("trim did not load calibration");

	trim_read_a: assert property (@(posedge clock) disable iff (srst) // [R13]
		$past(sfr.rd && (rd_coarse || rd_fine)) |-> (!sfr_rdata[7] &&
		($past(rd_coarse) || sfr_rdata[7:6] == 2'h0)))
		else $error("unused trim bits read nonzero");

	coarse_wr_a: assert property (@(posedge clock) disable iff (srst) // [R10]
		wr_coarse |-> ##1 (coarse_trim == $past(sfr.wdata[6:0])))
		else $error("coarse trim write lost");

	fine_wr_a: assert property (@(posedge clock) disable iff (srst) // [R11]
		wr_fine |-> ##1 (fine_trim == $past(sfr.wdata[5:0])))
		else $error("fine trim write lost");

	boundary_a: assert property (@(posedge clock) disable iff (srst) // [R14]
		!$stable(act_sel_r) |-> $past(div_last))
		else $error("divider select changed mid period");

	sequence wake_taken_s;
		susp_r && wake_any && !(wr_ctrl && wr_susp);
	endsequence

	wake_clear_a: assert property (@(posedge clock) disable iff (srst) // [R3]
		wake_taken_s |-> ##1 !susp_r)
		else $error("wake did not clear suspend");

	susp_stop_a: assert property (@(posedge clock) disable iff (srst) // [R3]
		susp_r |-> ##1 !system_clock_tick)
		else $error("system clock ran while suspended");

	div_stop_a: assert property (@(posedge clock) disable iff (srst) // [R3]
		!osc_run |-> ##1 !int_osc_div_tick)
		else $error("divided tick while oscillator stopped");

	off_stop_a: assert property (@(posedge clock) disable iff (srst) // [R1]
		(osc_enable_field_r != IOC_EN_RUN) |-> !osc_run)
		else $error("oscillator runs outside run mode");

	run_write_a: assert property (@(posedge clock) disable iff (srst) // [R1]
		(wr_ctrl && wr_en_field == IOC_EN_RUN && !wr_susp && !susp_r) |-> ##1 osc_run)
		else $error("run mode write did not start oscillator");

	susp_race_a: assert property (@(posedge clock) disable iff (srst) // [R2]
		(wr_ctrl && wr_susp && wake_any) |-> ##1 susp_r)
		else $error("suspend write lost against wake");

	ready_low_a: assert property (@(posedge clock) disable iff (srst) // [R5]
		(sfr.rd && rd_ctrl && !osc_run) |-> ##1 !sfr_rdata[IOC_RDY_BIT])
		else $error("ready flag set while oscillator stopped");

	ctrl_fields_a: assert property (@(posedge clock) disable iff (srst) // [R1] [R2]
		(sfr.rd && rd_ctrl) |-> ##1
		(sfr_rdata[IOC_EN_MSB:IOC_EN_LSB] == $past(osc_enable_field_r) &&
		sfr_rdata[IOC_SUSP_BIT] == $past(susp_r)))
		else $error("enable or suspend field read wrong");

	sel_write_a: assert property (@(posedge clock) disable iff (srst) // [R7]
		wr_ctrl |-> ##1 (system_clock_divide_select_r == $past(sfr.wdata[2:0])))
		else $error("divider select write lost");

	sel_read_a: assert property (@(posedge clock) disable iff (srst) // [R7]
		(sfr.rd && rd_ctrl) |-> ##1 (sfr_rdata[2:0] == $past(system_clock_divide_select_r)))
		else $error("divider select read wrong");

	period_len_a: assert property (@(posedge clock) disable iff (srst) // [R7]
		div_last |-> ((per_cnt_r + 8'h01) == (({1'b0, IOC_DIV_MASK} + 8'h01) >> act_sel_r)))
		else $error("divided period has wrong length");

	per_range_a: assert property (@(posedge clock) disable iff (srst) // [R7]
		per_cnt_r <= ({1'b0, IOC_DIV_MASK} >> act_sel_r))
		else $error("divider counted past its period");

	tick_once_a: assert property (@(posedge clock) disable iff (srst) // [R7]
		(int_osc_div_tick && act_sel_r != IOC_SEL_DIV1) |-> ##1 !int_osc_div_tick)
		else $error("divided tick longer than one cycle");

	sel_load_a: assert property (@(posedge clock) disable iff (srst) // [R14]
		div_last |-> ##1 (act_sel_r == $past(system_clock_divide_select_r)))
		else $error("pending divider select not taken at boundary");

	sys_follows_a: assert property (@(posedge clock) disable iff (srst) // [R9]
		system_clock_tick |-> int_osc_div_tick)
		else $error("system clock tick without divided tick");

	src_pass_a: assert property (@(posedge clock) disable iff (srst) // [R9]
		(div_last && clock_source_select == IOC_SRC_INTOSC) |-> ##1 system_clock_tick)
		else $error("divided tick not passed to system clock");

	coarse_hold_a: assert property (@(posedge clock) disable iff (srst) // [R10]
		!wr_coarse |-> ##1 $stable(coarse_trim))
		else $error("coarse trim changed without write");

	fine_hold_a: assert property (@(posedge clock) disable iff (srst) // [R11]
		!wr_fine |-> ##1 $stable(fine_trim))
		else $error("fine trim changed without write");

endmodule // ioc_ctrl

// ===== ioc_ctrl_tb.sv
`timescale 1ns/10ps
module ioc_ctrl_tb;
	import ioc_pkg::*;
	logic clock, srst, osc_tick, osc_at_freq, osc_run, div_t, sys_t;
	ioc_sfr_t sfr;
	ioc_wake_t wake;
	logic [7:0] sfr_rdata;
	logic [6:0] cal_c, coarse_trim;
	logic [5:0] cal_f, fine_trim;
	logic [1:0] src;
	int n_mismatch, tests_run, n;
	ioc_ctrl ioc_ctrl_i (.clock(clock), .srst(srst), .sfr(sfr), .sfr_rdata(sfr_rdata),
		.wake(wake), .cal_coarse(cal_c), .cal_fine(cal_f), .osc_tick(osc_tick),
		.osc_at_freq(osc_at_freq), .clock_source_select(src), .osc_run(osc_run),
		.coarse_trim(coarse_trim), .fine_trim(fine_trim), .int_osc_div_tick(div_t),
		.system_clock_tick(sys_t));
	initial begin
		clock = 0;
		forever #25 clock = ~clock;
	end
	task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done;
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic step;
		@(posedge clock);
		#5;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		sfr.addr = a; sfr.wdata = d; sfr.wr = 1;
		step;
		sfr.wr = 0;
		step;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] exp, string what);
		sfr.addr = a; sfr.rd = 1;
		step;
		sfr.rd = 0;
		chk(what, sfr_rdata, exp);
		step;
	endtask
	// counts cycles up to the next divided tick; bounded so a dead divider ends the run
	task automatic gap(output int k);
		k = 1;
		step;
		while (div_t !== 1'b1 && k < 300) begin
			step;
			k++;
		end
		if (k >= 300) begin
			n_mismatch++;
			test_done;
		end
	endtask
	task automatic do_reset(logic [6:0] c, logic [5:0] f);
		cal_c = c; cal_f = f; srst = 1;
		repeat (10) step;
		srst = 0;
		chk("coarse out", {1'b0, coarse_trim}, {1'b0, c});
		rd(IOC_COARSE_ADDR, {1'b0, c}, "coarse reset");
		rd(IOC_FINE_ADDR, {2'b00, f}, "fine reset");
	endtask
	task automatic t_ctrl;
		rd(IOC_CTRL_ADDR, 8'hd0, "ctrl reset ready");
		osc_at_freq = 0;
		rd(IOC_CTRL_ADDR, 8'hc0, "ctrl not ready");
		osc_at_freq = 1;
		wr(IOC_CTRL_ADDR, 8'hd3); // ready bit write-ignored, reserved written 0
		rd(IOC_CTRL_ADDR, 8'hd3, "ctrl reserved");
		rd(8'h9f, 8'h00, "unmapped");
		for (int e = 0; e < 4; e++) begin
			wr(IOC_CTRL_ADDR, {e[1:0], 6'h07});
			chk("osc run", osc_run, e == 3);
		end
	endtask
	task automatic t_trims;
		wr(IOC_COARSE_ADDR, 8'hff);
		wr(IOC_FINE_ADDR, 8'hff);
		rd(IOC_COARSE_ADDR, 8'h7f, "coarse ff");
		rd(IOC_FINE_ADDR, 8'h3f, "fine ff");
		chk("fine out", fine_trim, 8'h3f);
		wr(IOC_COARSE_ADDR, 8'h00);
		rd(IOC_COARSE_ADDR, 8'h00, "coarse 00");
		chk("coarse out", coarse_trim, 8'h00);
	endtask
	task automatic t_suspend;
		for (int i = 0; i < 5; i++) begin
			wr(IOC_CTRL_ADDR, 8'he7); // zero-tc bias taken as already set
			wake = 6'b000011; // comparator high must not wake
			repeat (3) step;
			chk("suspended", osc_run, 0);
			rd(IOC_CTRL_ADDR, 8'he7, "ctrl suspended");
			repeat (20) begin
				step;
				chk("no tick", div_t, 0);
				chk("no system_clock", sys_t, 0);
			end
			wake = (i < 4) ? 6'(1 << (i + 2)) : 6'b000010;
			step;
			chk("woken", osc_run, 1);
			wake = '0;
		end
	endtask
	task automatic t_race;
		wake = 6'b000100;
		sfr.addr = IOC_CTRL_ADDR;
		sfr.wdata = 8'he7; // zero-tc bias taken as already set
		sfr.wr = 1;
		step;
		sfr.wr = 0;
		chk("suspend beats wake", osc_run, 0);
		step;
		chk("wake still ends it", osc_run, 1);
		wake = '0;
		step;
	endtask
	task automatic t_divider;
		for (int s = 0; s < 8; s++) begin
			wr(IOC_CTRL_ADDR, {5'b11000, s[2:0]});
			gap(n);
			if (s == 1) chk("switch mid period", 8'(n), 8'h7e);
			gap(n);
			gap(n);
			chk("divisor", 8'(n), 8'h80 >> s);
			chk("system_clock tick", sys_t, 1);
		end
		src = 2'b01;
		gap(n);
		chk("system_clock other src", sys_t, 0);
		src = 2'b00;
	endtask
	initial begin
		sfr = '0; wake = '0; osc_tick = 1; osc_at_freq = 1; src = 2'b00;
		do_reset(7'h55, 6'h2a);
		t_ctrl;
		t_trims;
		t_suspend;
		t_race;
		t_divider;
		do_reset(7'h0a, 6'h15);
		rd(IOC_CTRL_ADDR, 8'hd0, "ctrl after reset");
		gap(n);
		gap(n);
		chk("divisor after reset", 8'(n), 8'h80);
		test_done;
	end
endmodule // ioc_ctrl_tb
